//--- hdl/sdpi_map.svh
/*
  Pin widths, mode word fields, burst masks and reset values of the SDRAM pin model.
  Assumes it is included by the package and by every design file that needs a figure.
*/
`ifndef SDPI_MAP_SVH
`define SDPI_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SDPI_ROW_W 13
`define SDPI_COL_W 9
`define SDPI_BANK_W 2
`define SDPI_NBANK 4
`define SDPI_DATA_W 16
`define SDPI_BYTE_W 8
`define SDPI_NBYTE 2
`define SDPI_MEM_AW 24
`define SDPI_AP_BIT 10

// ----------------------------------------------------------------
// Mode word fields
// ----------------------------------------------------------------
`define SDPI_BL_LSB 0
`define SDPI_BL_W 3
`define SDPI_CL_LSB 4
`define SDPI_CL_W 3
`define SDPI_BL_1 3'h0
`define SDPI_BL_2 3'h1
`define SDPI_BL_4 3'h2
`define SDPI_BL_8 3'h3
`define SDPI_BL_FULL 3'h7
`define SDPI_CL_3 3'h3

// ----------------------------------------------------------------
// Burst column masks
// ----------------------------------------------------------------
`define SDPI_MASK_1 9'h000
`define SDPI_MASK_2 9'h001
`define SDPI_MASK_4 9'h003
`define SDPI_MASK_8 9'h007
`define SDPI_MASK_FULL 9'h1ff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDPI_MODE_RST 13'h0000
`define SDPI_ROW_RST 13'h0000
`define SDPI_COL_RST 9'h000
`define SDPI_COL_ONE 9'h001
`define SDPI_DATA_RST 16'h0000

`endif

//--- hdl/sdpi_pkg.sv
/*
  Types of the SDRAM pin model: command codes and power states.
  Assumes the constant header sits beside it.
*/
`include "sdpi_map.svh"

package sdpi_pkg;

  // Row strobe, column strobe and write strobe, in that order, all active low
  typedef enum logic [2:0] {
    CMD_MODE_SET   = 3'b000,
    CMD_REFRESH    = 3'b001,
    CMD_PRECHARGE  = 3'b010,
    CMD_ACTIVATE   = 3'b011,
    CMD_WRITE      = 3'b100,
    CMD_READ       = 3'b101,
    CMD_BURST_STOP = 3'b110,
    CMD_NO_OP      = 3'b111
  } sdpi_cmd_e;

  typedef enum logic [1:0] {
    PWR_RUN      = 2'b00,
    PWR_DOWN     = 2'b01,
    PWR_SUSPEND  = 2'b10,
    PWR_SELF_REF = 2'b11
  } sdpi_pwr_e;

endpackage

//--- hdl/sdpi_mem_if.sv
/*
  Link between the pin logic and the cell array: one access per clock.
  Assumes the array answers a read with registered data one clock later.
*/
`timescale 1ns/1ps
`include "sdpi_map.svh"

interface sdpi_mem_if;
  logic re;
  logic we;
  logic [`SDPI_NBYTE-1:0] be;
  logic [`SDPI_MEM_AW-1:0] addr;
  logic [`SDPI_DATA_W-1:0] wdata;
  logic [`SDPI_DATA_W-1:0] rdata;

  modport ctrl (output re, output we, output be, output addr, output wdata, input rdata);
  modport mem (input re, input we, input be, input addr, input wdata, output rdata);
endinterface

//--- hdl/sdpi_mem.sv
/*
  Cell array of all four banks, byte-writable, with a registered read port.
  Assumes one clock and that contents are undefined until written.
*/
`timescale 1ns/1ps
`include "sdpi_map.svh"

module sdpi_mem
  import sdpi_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Access port
  sdpi_mem_if.mem port
);

  logic [`SDPI_DATA_W-1:0] store_q [0:(1 << `SDPI_MEM_AW)-1];
  logic [`SDPI_DATA_W-1:0] rdata_q;

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  // One process owns the whole array; per-lane processes would each drive all of it
  always_ff @(posedge clock_i) begin
    for (int b = 0; b < `SDPI_NBYTE; b++) begin
      if (port.we && port.be[b]) begin
        store_q[port.addr][b*`SDPI_BYTE_W +: `SDPI_BYTE_W] <=
          port.wdata[b*`SDPI_BYTE_W +: `SDPI_BYTE_W];
      end
    end
  end

  // Read data holds between reads so a suspended burst keeps its word
  always_ff @(posedge clock_i) begin
    if (port.re) begin
      rdata_q <= store_q[port.addr];
    end
  end

  assign port.rdata = rdata_q;

endmodule

//--- hdl/sdpi_top.sv
/*
  Command, address and data pin logic of a four-bank 16-bit SDRAM.
  Assumes the controller runs on clock_i and sets every pin up before each rising edge.
*/
// How it works
// - Row on thirteen lines, column on nine
// - Bank select picks bank for row/column
// - Chip select high: commands ignored, work continues
// - Row, column, write strobes decode command
// - Read mask floats byte two clocks later
// - Write mask blocks byte same cycle
// - All inputs sampled on rising edge
// - Clock enable low: down, suspend, self-refresh
// - All four strobes low sets mode word
`timescale 1ns/1ps
`include "sdpi_map.svh"

module sdpi_top
  import sdpi_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [`SDPI_BANK_W-1:0] bank_select_i,
  input wire logic [`SDPI_ROW_W-1:0] addr_i,
  input wire logic lower_byte_mask_i,
  input wire logic upper_byte_mask_i,
  // Data pins
  input wire logic [`SDPI_DATA_W-1:0] data_pins_i,
  output logic [`SDPI_DATA_W-1:0] data_pins_o,
  output logic [`SDPI_NBYTE-1:0] data_pins_oe_n_o,
  // Status
  output logic [1:0] power_state_o,
  output logic [`SDPI_ROW_W-1:0] mode_word_o,
  output logic [`SDPI_NBANK-1:0] bank_open_o
);

  sdpi_mem_if mem ();

  sdpi_cmd_e cmd;
  sdpi_pwr_e pwr_q;
  logic [`SDPI_NBYTE-1:0] dqm;
  logic run;
  logic take;
  logic access_cmd;
  logic stop_now;
  logic cl3;
  logic [`SDPI_COL_W-1:0] mask;
  logic [`SDPI_ROW_W-1:0] mode_q;
  logic [`SDPI_NBANK-1:0] open_q;
  logic [`SDPI_ROW_W-1:0] row_q [`SDPI_NBANK];
  logic burst_act_q;
  logic burst_wr_q;
  logic [`SDPI_BANK_W-1:0] bank_q;
  logic [`SDPI_COL_W-1:0] base_q;
  logic [`SDPI_COL_W-1:0] cnt_q;
  logic rv1_q;
  logic rv2_q;
  logic [`SDPI_DATA_W-1:0] d2_q;
  logic [`SDPI_NBYTE-1:0] dqm_d1_q;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [`SDPI_COL_W-1:0] burst_mask(input logic [`SDPI_BL_W-1:0] code);
    case (code)
      `SDPI_BL_2: burst_mask = `SDPI_MASK_2;
      `SDPI_BL_4: burst_mask = `SDPI_MASK_4;
      `SDPI_BL_8: burst_mask = `SDPI_MASK_8;
      `SDPI_BL_FULL: burst_mask = `SDPI_MASK_FULL;
      default: burst_mask = `SDPI_MASK_1;
    endcase
  endfunction

  // Sequential order: the count wraps inside the burst block, no carry out of it
  function automatic logic [`SDPI_COL_W-1:0] burst_col(input logic [`SDPI_COL_W-1:0] base,
                                                       input logic [`SDPI_COL_W-1:0] cnt,
                                                       input logic [`SDPI_COL_W-1:0] m);
    burst_col = (base & ~m) | ((base + cnt) & m);
  endfunction

  // Rising edge sampling
  // Pins are taken directly at the edge; the controller shares clock_i.
  assign dqm = {upper_byte_mask_i, lower_byte_mask_i};
  assign cmd = sdpi_cmd_e'({ras_n_i, cas_n_i, we_n_i});
  assign run = (pwr_q == PWR_RUN) && cke_i;
  assign take = run && !cs_n_i;
  assign access_cmd = take && (cmd == CMD_READ || cmd == CMD_WRITE) && open_q[bank_select_i];
  assign stop_now = take && cmd == CMD_BURST_STOP;
  assign mask = burst_mask(mode_q[`SDPI_BL_LSB +: `SDPI_BL_W]);
  assign cl3 = mode_q[`SDPI_CL_LSB +: `SDPI_CL_W] == `SDPI_CL_3;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pwr_q <= PWR_RUN;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (!cke_i) begin
            if (burst_act_q || rv1_q || rv2_q) begin
              pwr_q <= PWR_SUSPEND;
            end else if (!cs_n_i && cmd == CMD_REFRESH) begin
              pwr_q <= PWR_SELF_REF;
            end else begin
              pwr_q <= PWR_DOWN;
            end
          end
        end
        PWR_DOWN, PWR_SUSPEND, PWR_SELF_REF: begin
          if (cke_i) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode word and banks
  // ----------------------------------------------------------------
  // Reset value is only a known start; controllers must program it anyway.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mode_q <= `SDPI_MODE_RST;
    end else if (take && cmd == CMD_MODE_SET) begin
      mode_q <= addr_i;
    end
  end

  for (genvar b = 0; b < `SDPI_NBANK; b++) begin : g_bank
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        open_q[b] <= 1'b0;
        row_q[b] <= `SDPI_ROW_RST;
      end else if (take) begin
        if (cmd == CMD_ACTIVATE && bank_select_i == `SDPI_BANK_W'(b)) begin
          open_q[b] <= 1'b1;
          row_q[b] <= addr_i;
        end else if (cmd == CMD_PRECHARGE &&
                     (addr_i[`SDPI_AP_BIT] || bank_select_i == `SDPI_BANK_W'(b))) begin
          open_q[b] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencing
  // ----------------------------------------------------------------
  // A new access overrides the burst in flight, read or write alike.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
      bank_q <= '0;
      base_q <= `SDPI_COL_RST;
      cnt_q <= `SDPI_COL_RST;
    end else if (run) begin
      if (access_cmd) begin
        burst_act_q <= mask != `SDPI_MASK_1;
        burst_wr_q <= cmd == CMD_WRITE;
        bank_q <= bank_select_i;
        base_q <= addr_i[`SDPI_COL_W-1:0];
        cnt_q <= `SDPI_COL_ONE;
      end else if (stop_now) begin
        burst_act_q <= 1'b0;
      end else if (burst_act_q) begin
        cnt_q <= cnt_q + `SDPI_COL_ONE;
        if (cnt_q == mask) begin
          burst_act_q <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    mem.re = 1'b0;
    mem.we = 1'b0;
    mem.be = '0;
    mem.addr = '0;
    mem.wdata = data_pins_i;
    if (access_cmd) begin
      mem.addr = {bank_select_i, row_q[bank_select_i], addr_i[`SDPI_COL_W-1:0]};
      mem.re = cmd == CMD_READ;
      mem.we = cmd == CMD_WRITE;
      mem.be = ~dqm;
    end else if (run && burst_act_q && !stop_now) begin
      mem.addr = {bank_q, row_q[bank_q], burst_col(base_q, cnt_q, mask)};
      mem.re = !burst_wr_q;
      mem.we = burst_wr_q;
      mem.be = ~dqm;
    end
  end

  sdpi_mem u_mem (
    .clock_i(clock_i),
    .port(mem.mem)
  );

  // ----------------------------------------------------------------
  // Read pipe and data drivers
  // ----------------------------------------------------------------
  // Everything freezes with the clock enable, so a suspended read holds its word.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rv1_q <= 1'b0;
      rv2_q <= 1'b0;
      d2_q <= `SDPI_DATA_RST;
    end else if (run) begin
      rv1_q <= mem.re;
      rv2_q <= rv1_q;
      d2_q <= mem.rdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dqm_d1_q <= '0;
      data_pins_o <= `SDPI_DATA_RST;
      data_pins_oe_n_o <= '1;
    end else if (run) begin
      dqm_d1_q <= dqm;
      data_pins_o <= cl3 ? d2_q : mem.rdata;
      // Mask floats byte after two clocks
      data_pins_oe_n_o <= ~({`SDPI_NBYTE{cl3 ? rv2_q : rv1_q}} & ~dqm_d1_q);
    end
  end

  assign power_state_o = pwr_q;
  assign mode_word_o = mode_q;
  assign bank_open_o = open_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_row_latched;
    take && cmd == CMD_ACTIVATE |=> row_q[$past(bank_select_i)] == $past(addr_i);
  endproperty
  a_row_latched: assert property (p_row_latched) else $error("row not latched");

  property p_bank_open;
    take && cmd == CMD_ACTIVATE |=> bank_open_o[$past(bank_select_i)] ##1
      (!access_cmd || mem.addr[`SDPI_MEM_AW-1 -: `SDPI_BANK_W] == bank_select_i);
  endproperty
  a_bank_open: assert property (p_bank_open) else $error("bank select misused");

  property p_deselect;
    run && cs_n_i |=> $stable(mode_q) && $stable(open_q);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected command acted");

  property p_precharge_all;
    take && cmd == CMD_PRECHARGE && addr_i[`SDPI_AP_BIT] |=> bank_open_o == '0;
  endproperty
  a_precharge_all: assert property (p_precharge_all) else $error("banks left open");

  property p_read_mask;
    (run && lower_byte_mask_i) ##1 run |=> data_pins_oe_n_o[0];
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("masked byte driven");

  property p_write_mask;
    mem.we && upper_byte_mask_i |-> !mem.be[1];
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("masked byte written");

  property p_read_cl3;
    (access_cmd && cmd == CMD_READ && cl3 && dqm == '0) ##1 (run && dqm == '0) [*2]
      |=> data_pins_oe_n_o == '0;
  endproperty
  a_read_cl3: assert property (p_read_cl3) else $error("read data not driven");

  property p_suspend;
    pwr_q == PWR_RUN && !cke_i && burst_act_q |=> power_state_o == PWR_SUSPEND;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not entered");

  property p_mode_set;
    take && cmd == CMD_MODE_SET |=> mode_word_o == $past(addr_i);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode word not set");

  c_read: cover property (access_cmd && cmd == CMD_READ ##[1:4] data_pins_oe_n_o == '0);
  c_write: cover property (access_cmd && cmd == CMD_WRITE && dqm == '0);
  c_self_ref: cover property (power_state_o == PWR_SELF_REF);

endmodule

//--- tb/sdpi_ctl_model.sv
/*
  Controller model on the far side of the SDRAM pins: power-up sequence and command tasks.
  Assumes the bench calls one task at a time; each returns just after a rising edge.
*/
`timescale 1ns/1ps

module sdpi_ctl_model
  import sdpi_pkg::*;
#(
  parameter int CLK_NS = 100,
  parameter int PAUSE_NS = 200000,
  parameter int RSC_CYC = 2,
  parameter int GAP_CYC = 2
)(
  // Clock
  input wire logic clock_i,
  // Pins toward the device
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [1:0] bank_select_o,
  output logic [12:0] addr_o,
  output logic [1:0] mask_o,
  output logic [15:0] data_o
);
  localparam int PAUSE_CYC = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [12:0] MODE = 13'h0032;

  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b0;
    {ras_n_o, cas_n_o, we_n_o} = CMD_NO_OP;
    bank_select_o = 2'h0;
    addr_o = 13'h0000;
    mask_o = 2'h3;
    data_o = 16'h0000;
  end

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask

  // Pins are set once after an edge and held until the next edge takes them
  task automatic issue(input logic ke, input logic cs, input sdpi_cmd_e cmd,
                       input logic [1:0] ba, input logic [12:0] a,
                       input logic [15:0] d, input logic [1:0] m);
    cke_o = ke;
    cs_n_o = cs;
    {ras_n_o, cas_n_o, we_n_o} = cmd;
    bank_select_o = ba;
    addr_o = a;
    data_o = d;
    mask_o = m;
    step(1);
  endtask

  // Released data lines show the inverse, so a stale word is never mistaken for data
  task automatic idle(input int n, input logic [1:0] m);
    cke_o = 1'b1;
    cs_n_o = 1'b0;
    {ras_n_o, cas_n_o, we_n_o} = CMD_NO_OP;
    mask_o = m;
    data_o = ~data_o;
    step(n);
  endtask

  task automatic init;
    idle(PAUSE_CYC, 2'h3);
    issue(1'b1, 1'b0, CMD_PRECHARGE, 2'h0, 13'h0400, data_o, 2'h3);
    idle(GAP_CYC, 2'h3);
    issue(1'b1, 1'b0, CMD_MODE_SET, 2'h0, MODE, data_o, 2'h3);
    idle(RSC_CYC, 2'h3);
    repeat (8) begin
      issue(1'b1, 1'b0, CMD_REFRESH, 2'h0, 13'h0000, data_o, 2'h3);
      idle(GAP_CYC, 2'h3);
    end
  endtask
endmodule

//--- tb/testbench.sv
/*
  Self-checking bench of the SDRAM pin logic, driven through the controller model.
  Assumes burst of four and read latency three, as the model programs at start-up;
  the last scenario reprograms burst of two and read latency two.
*/
`timescale 1ns/1ps

module testbench
  import sdpi_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  int n_fail = 0;
  int total_checks = 0;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba, mask, oe_n, ps;
  logic [12:0] addr, mode;
  logic [15:0] dq_w, dq_r;
  logic [3:0] bopen;

  always #50 clock = ~clock;

  sdpi_top dut (.clock_i(clock), .reset_i(reset), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_i(ba),
    .addr_i(addr), .lower_byte_mask_i(mask[0]), .upper_byte_mask_i(mask[1]),
    .data_pins_i(dq_w), .data_pins_o(dq_r), .data_pins_oe_n_o(oe_n),
    .power_state_o(ps), .mode_word_o(mode), .bank_open_o(bopen));

  sdpi_ctl_model ctl (.clock_i(clock), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .bank_select_o(ba), .addr_o(addr),
    .mask_o(mask), .data_o(dq_w));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic ke, input logic cs, input sdpi_cmd_e c,
                     input logic [1:0] b, input logic [12:0] a, input logic [1:0] m);
    ctl.issue(ke, cs, c, b, a, dq_w, m);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_init;
    ctl.init();
    chk("mode word", 16'h0032, 16'(mode));
    chk("no drive in pause", 16'h0003, 16'(oe_n));
    chk("power state", 16'h0000, 16'(ps));
  endtask

  task automatic t_act;
    cmd(1'b1, 1'b1, CMD_ACTIVATE, 2'h1, 13'h1abc, 2'h0);
    chk("deselected activate", 16'h0000, 16'(bopen));
    cmd(1'b1, 1'b0, CMD_ACTIVATE, 2'h2, 13'h1abc, 2'h0);
    chk("bank open", 16'h0004, 16'(bopen));
  endtask

  task automatic t_wr;
    logic [15:0] w [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    logic [15:0] v [4] = '{16'ha0a0, 16'hb1b1, 16'hc2c2, 16'hd3d3};
    logic [1:0] m [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    logic [15:0] e [4] = '{16'ha0a0, 16'h22b1, 16'hc233, 16'h4444};
    for (int i = 0; i < 4; i++) begin
      ctl.issue(1'b1, 1'b0, i == 0 ? CMD_WRITE : CMD_NO_OP, 2'h2, 13'h0000, w[i], 2'h0);
    end
    // Masked overwrite: each masked byte must keep the first burst's value
    for (int i = 0; i < 4; i++) begin
      ctl.issue(1'b1, 1'b0, i == 0 ? CMD_WRITE : CMD_NO_OP, 2'h2, 13'h0000, v[i], m[i]);
    end
    cmd(1'b1, 1'b0, CMD_READ, 2'h2, 13'h1a00, 2'h0);
    cmd(1'b1, 1'b1, CMD_ACTIVATE, 2'h0, 13'h0000, 2'h0);
    cmd(1'b1, 1'b0, CMD_NO_OP, 2'h0, 13'h0000, 2'h1);
    chk("read word 0", e[0], dq_r);
    chk("oe beat 0", 16'h0000, 16'(oe_n));
    ctl.idle(1, 2'h0);
    chk("read word 1 upper", 16'(e[1][15:8]), 16'(dq_r[15:8]));
    chk("oe beat 1", 16'h0001, 16'(oe_n));
    ctl.idle(1, 2'h0);
    chk("read word 2", e[2], dq_r);
    chk("oe beat 2", 16'h0000, 16'(oe_n));
    ctl.idle(1, 2'h0);
    chk("read word 3", e[3], dq_r);
    ctl.idle(1, 2'h0);
    chk("oe after burst", 16'h0003, 16'(oe_n));
    chk("deselect left banks", 16'h0004, 16'(bopen));
  endtask

  task automatic t_stop;
    cmd(1'b1, 1'b0, CMD_READ, 2'h2, 13'h0000, 2'h0);
    cmd(1'b1, 1'b0, CMD_BURST_STOP, 2'h2, 13'h0000, 2'h0);
    ctl.idle(1, 2'h0);
    chk("stop word 0", 16'ha0a0, dq_r);
    ctl.idle(1, 2'h0);
    chk("oe after stop", 16'h0003, 16'(oe_n));
  endtask

  task automatic t_power;
    cmd(1'b1, 1'b0, CMD_READ, 2'h2, 13'h0000, 2'h0);
    cmd(1'b0, 1'b0, CMD_NO_OP, 2'h0, 13'h0000, 2'h0);
    chk("suspend", 16'h0002, 16'(ps));
    cmd(1'b1, 1'b0, CMD_NO_OP, 2'h0, 13'h0000, 2'h0);
    chk("resume", 16'h0000, 16'(ps));
    ctl.idle(6, 2'h0);
    cmd(1'b1, 1'b0, CMD_PRECHARGE, 2'h2, 13'h0000, 2'h0);
    chk("precharged", 16'h0000, 16'(bopen));
    cmd(1'b1, 1'b0, CMD_READ, 2'h2, 13'h0000, 2'h0);
    ctl.idle(3, 2'h0);
    chk("closed bank read", 16'h0003, 16'(oe_n));
    cmd(1'b0, 1'b0, CMD_NO_OP, 2'h0, 13'h0000, 2'h0);
    chk("power-down", 16'h0001, 16'(ps));
    cmd(1'b1, 1'b0, CMD_ACTIVATE, 2'h0, 13'h0000, 2'h0);
    chk("exit edge takes nothing", 16'h0000, 16'(bopen));
    cmd(1'b0, 1'b0, CMD_REFRESH, 2'h0, 13'h0000, 2'h0);
    chk("self refresh", 16'h0003, 16'(ps));
    ctl.idle(1, 2'h0);
    chk("run again", 16'h0000, 16'(ps));
  endtask

  // Latency two, burst of two from an odd column: wraps to the even one
  task automatic t_cl2;
    cmd(1'b1, 1'b0, CMD_MODE_SET, 2'h0, 13'h0021, 2'h0);
    chk("mode word cl2", 16'h0021, 16'(mode));
    ctl.idle(2, 2'h0);
    cmd(1'b1, 1'b0, CMD_ACTIVATE, 2'h1, 13'h0155, 2'h0);
    ctl.issue(1'b1, 1'b0, CMD_WRITE, 2'h1, 13'h0005, 16'h5a5a, 2'h0);
    ctl.issue(1'b1, 1'b0, CMD_NO_OP, 2'h1, 13'h0000, 16'h6b6b, 2'h0);
    cmd(1'b1, 1'b0, CMD_READ, 2'h1, 13'h0005, 2'h0);
    ctl.idle(1, 2'h0);
    chk("cl2 word 0", 16'h5a5a, dq_r);
    chk("cl2 oe beat 0", 16'h0000, 16'(oe_n));
    ctl.idle(1, 2'h0);
    chk("cl2 word 1", 16'h6b6b, dq_r);
    chk("cl2 oe beat 1", 16'h0000, 16'(oe_n));
    ctl.idle(1, 2'h0);
    chk("cl2 oe after burst", 16'h0003, 16'(oe_n));
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    #1;
    reset = 1'b0;
    t_init();
    t_act();
    t_wr();
    t_stop();
    t_power();
    t_cl2();
    tally_and_finish();
  end

  // Start-up pause is about 2000 cycles, the scenarios under 100 more
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule
